// *** pkg/tcw_pkg.sv ***
package tcw_pkg;

   // ------------------------------------------------------------------
   // Register port geometry and register offsets
   // ------------------------------------------------------------------
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;

   localparam logic [ADDR_W-1:0] OFS_CTRL_A = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_CTRL_B = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_COUNT  = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_CMP_A  = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_CMP_B  = 3'h4;
   localparam logic [ADDR_W-1:0] OFS_FLAGS  = 3'h5;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CA_ACT_A_MSB = 7;
   localparam int CA_ACT_B_MSB = 5;
   localparam int CA_WGM_MSB   = 1;
   localparam int CB_FORCE_A   = 7;
   localparam int CB_FORCE_B   = 6;
   localparam int CB_WGM_HI    = 3;
   localparam int CB_CS_MSB    = 2;
   localparam int FL_OVF       = 0;
   localparam int FL_CMP_A     = 1;
   localparam int FL_CMP_B     = 2;

   // ------------------------------------------------------------------
   // Output action codes and waveform mode codes
   // ------------------------------------------------------------------
   localparam logic [1:0] ACT_NONE   = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR  = 2'h2;
   localparam logic [1:0] ACT_SET    = 2'h3;

   localparam logic [2:0] WGM_NORMAL    = 3'h0;
   localparam logic [2:0] WGM_CTC       = 3'h2;
   localparam logic [2:0] WGM_FAST_MAX  = 3'h3;
   localparam logic [2:0] WGM_FAST_CMPA = 3'h7;
   localparam int         WGM_HI_BIT    = 2;

   localparam logic [7:0] COUNT_MAX    = 8'hFF;
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   localparam logic [7:0] COUNT_ONE    = 8'h01;

   // ------------------------------------------------------------------
   // Prescaler selects and terminal masks
   // ------------------------------------------------------------------
   localparam logic [2:0] CS_STOP    = 3'h0;
   localparam logic [2:0] CS_DIV1    = 3'h1;
   localparam logic [2:0] CS_DIV8    = 3'h2;
   localparam logic [2:0] CS_DIV64   = 3'h3;
   localparam logic [2:0] CS_DIV256  = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;

   localparam logic [9:0] PRE_ONE       = 10'h001;
   localparam logic [9:0] PRE_MASK_8    = 10'h007;
   localparam logic [9:0] PRE_MASK_64   = 10'h03F;
   localparam logic [9:0] PRE_MASK_256  = 10'h0FF;
   localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_NORMAL = 3'b001,
      MODE_CTC    = 3'b010,
      MODE_FAST   = 3'b100
   } tcw_mode_type;

   typedef struct packed {
      logic [9:0] pre;
      logic [7:0] count;
      logic [7:0] cmpA;
      logic [7:0] cmpB;
      logic [7:0] bufA;
      logic [7:0] bufB;
      logic [1:0] actA;
      logic [1:0] actB;
      logic [2:0] wgm;
      logic [2:0] clkSel;
      logic       ovf;
      logic       flagA;
      logic       flagB;
      logic       ocA;
      logic       ocB;
      logic       block;
      logic       prevFast;
      logic       pinA;
      logic       pinB;
      logic       oeA_n;
      logic       oeB_n;
      logic [7:0] rdData;
   } tcw_state_type;

   localparam tcw_state_type TCW_STATE_RESET = '{
      oeA_n   : 1'b1,
      oeB_n   : 1'b1,
      default : '0
   };

endpackage

// *** rtl/tcw_waveform_gen.sv ***
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module tcw_waveform_gen (
   input  wire logic                       clk,
   input  wire logic                       reset_n,
   input  wire logic [tcw_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [tcw_pkg::DATA_W-1:0] regWrData,
   input  wire logic                       regWrite,
   input  wire logic                       regRead,
   output      logic [tcw_pkg::DATA_W-1:0] regRdData,
   input  wire logic                       portOutA,
   input  wire logic                       portOutB,
   input  wire logic                       pinDirectionBitA,
   input  wire logic                       pinDirectionBitB,
   output      logic                       pinOutA,
   output      logic                       pinOutB,
   output      logic                       pinOeA_n,
   output      logic                       pinOeB_n,
   output      logic                       compareOutputA,
   output      logic                       compareOutputB,
   output      logic                       overflowFlag,
   output      logic                       compareFlagA,
   output      logic                       compareFlagB
);
   import tcw_pkg::*;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   tcw_state_type s_r;
   tcw_state_type s_nxt;

   // Non-PWM action applied to a latch value.
   function automatic logic nonPwmLevel(input logic oc,
                                        input logic [1:0] act);
      logic lvl;
      lvl = oc;
      unique case (act)
         ACT_TOGGLE: lvl = ~oc;
         ACT_CLEAR:  lvl = 1'b0;
         ACT_SET:    lvl = 1'b1;
         default:    lvl = oc;
      endcase
      return lvl;
   endfunction

   // Level a fast PWM latch takes at bottom: set for non-inverting.
   function automatic logic bottomLevel(input logic [1:0] act);
      return (act == ACT_CLEAR);
   endfunction

   // Level taken on a fast PWM match; toggle only if allowed.
   function automatic logic fastMatchLevel(input logic oc,
                                           input logic [1:0] act,
                                           input logic togOk);
      logic lvl;
      lvl = oc;
      unique case (act)
         ACT_TOGGLE: lvl = togOk ? ~oc : oc;
         ACT_CLEAR:  lvl = 1'b0;
         ACT_SET:    lvl = 1'b1;
         default:    lvl = oc;
      endcase
      return lvl;
   endfunction

   tcw_mode_type mode;
   logic [7:0]   topValue;
   logic         tick;
   logic         matchA;
   logic         matchB;
   logic         atTop;
   logic         toggleOkA;

   // ------------------------------------------------------------------
   // Decode of mode, prescaler tick and comparators
   // ------------------------------------------------------------------
   always_comb begin
      unique case (s_r.wgm)
         WGM_NORMAL:    mode = MODE_NORMAL;
         WGM_CTC:       mode = MODE_CTC;
         WGM_FAST_MAX:  mode = MODE_FAST;
         WGM_FAST_CMPA: mode = MODE_FAST;
         default:       mode = MODE_NORMAL;
      endcase
      topValue = (s_r.wgm == WGM_FAST_CMPA) ? s_r.cmpA : COUNT_MAX;
      unique case (s_r.clkSel)
         CS_DIV1:    tick = 1'b1;
         CS_DIV8:    tick = (s_r.pre & PRE_MASK_8) == PRE_MASK_8;
         CS_DIV64:   tick = (s_r.pre & PRE_MASK_64) == PRE_MASK_64;
         CS_DIV256:  tick = (s_r.pre & PRE_MASK_256) == PRE_MASK_256;
         CS_DIV1024: tick = (s_r.pre & PRE_MASK_1024) == PRE_MASK_1024;
         default:    tick = 1'b0;
      endcase
      matchA    = (s_r.count == s_r.cmpA) && !s_r.block;
      matchB    = (s_r.count == s_r.cmpB) && !s_r.block;
      atTop     = (s_r.count == topValue);
      toggleOkA = s_r.wgm[WGM_HI_BIT];
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      s_nxt     = s_r;
      s_nxt.pre = (s_r.clkSel == CS_STOP) ? '0 : s_r.pre + PRE_ONE;

      // Clears first so that a flag raised in the same cycle survives.
      if (regWrite && regAddr == OFS_FLAGS) begin
         if (regWrData[FL_OVF])
            s_nxt.ovf = 1'b0;
         if (regWrData[FL_CMP_A])
            s_nxt.flagA = 1'b0;
         if (regWrData[FL_CMP_B])
            s_nxt.flagB = 1'b0;
      end

      if (tick) begin
         s_nxt.block = 1'b0;
         if (matchA)
            s_nxt.flagA = 1'b1;
         if (matchB)
            s_nxt.flagB = 1'b1;
         unique case (mode)
            MODE_NORMAL: begin
               s_nxt.count = s_r.count + COUNT_ONE;
               if (s_r.count == COUNT_MAX)
                  s_nxt.ovf = 1'b1;
               if (matchA)
                  s_nxt.ocA = nonPwmLevel(s_r.ocA, s_r.actA);
               if (matchB)
                  s_nxt.ocB = nonPwmLevel(s_r.ocB, s_r.actB);
            end
            MODE_CTC: begin
               // A compare value written below the count is simply
               // passed over; the counter wraps before matching.
               if (matchA)
                  s_nxt.count = COUNT_BOTTOM;
               else
                  s_nxt.count = s_r.count + COUNT_ONE;
               if (!matchA && s_r.count == COUNT_MAX)
                  s_nxt.ovf = 1'b1;
               if (matchA)
                  s_nxt.ocA = nonPwmLevel(s_r.ocA, s_r.actA);
               if (matchB)
                  s_nxt.ocB = nonPwmLevel(s_r.ocB, s_r.actB);
            end
            MODE_FAST: begin
               if (atTop) begin
                  s_nxt.count = COUNT_BOTTOM;
                  s_nxt.ovf   = 1'b1;
                  s_nxt.cmpA  = s_r.bufA;
                  s_nxt.cmpB  = s_r.bufB;
               end else begin
                  s_nxt.count = s_r.count + COUNT_ONE;
               end
               // Bottom wins over a match at top, so a compare value at
               // MAX holds a constant level and one at bottom gives a
               // single-tick spike.
               if (atTop && s_r.actA[1])
                  s_nxt.ocA = bottomLevel(s_r.actA);
               else if (matchA)
                  s_nxt.ocA = fastMatchLevel(s_r.ocA, s_r.actA,
                                             toggleOkA);
               if (atTop && s_r.actB[1])
                  s_nxt.ocB = bottomLevel(s_r.actB);
               else if (matchB)
                  s_nxt.ocB = fastMatchLevel(s_r.ocB, s_r.actB,
                                             1'b0);
            end
         endcase
      end

      // Entering fast PWM preloads the bottom level.
      s_nxt.prevFast = (mode == MODE_FAST);
      if (mode == MODE_FAST && !s_r.prevFast) begin
         if (s_r.actA[1])
            s_nxt.ocA = bottomLevel(s_r.actA);
         if (s_r.actB[1])
            s_nxt.ocB = bottomLevel(s_r.actB);
      end

      // CPU writes come last: they override counting and clearing.
      if (regWrite) begin
         unique case (regAddr)
            OFS_CTRL_A: begin
               s_nxt.actA = regWrData[CA_ACT_A_MSB -: 2];
               s_nxt.actB = regWrData[CA_ACT_B_MSB -: 2];
               s_nxt.wgm[1:0] = regWrData[CA_WGM_MSB -: 2];
            end
            OFS_CTRL_B: begin
               s_nxt.wgm[WGM_HI_BIT] = regWrData[CB_WGM_HI];
               s_nxt.clkSel = regWrData[CB_CS_MSB -: 3];
               // Forcing sets no flag and leaves the counter alone.
               if (mode != MODE_FAST) begin
                  if (regWrData[CB_FORCE_A])
                     s_nxt.ocA = nonPwmLevel(s_r.ocA, s_r.actA);
                  if (regWrData[CB_FORCE_B])
                     s_nxt.ocB = nonPwmLevel(s_r.ocB, s_r.actB);
               end
            end
            OFS_COUNT: begin
               s_nxt.count = regWrData;
               s_nxt.block = 1'b1;
            end
            OFS_CMP_A: begin
               s_nxt.bufA = regWrData;
               if (mode != MODE_FAST)
                  s_nxt.cmpA = regWrData;
            end
            OFS_CMP_B: begin
               s_nxt.bufB = regWrData;
               if (mode != MODE_FAST)
                  s_nxt.cmpB = regWrData;
            end
            default: begin
            end
         endcase
      end

      // Read data stands only in the cycle after the strobe.
      s_nxt.rdData = '0;
      if (regRead) begin
         unique case (regAddr)
            OFS_CTRL_A: begin
               s_nxt.rdData[CA_ACT_A_MSB -: 2] = s_r.actA;
               s_nxt.rdData[CA_ACT_B_MSB -: 2] = s_r.actB;
               s_nxt.rdData[CA_WGM_MSB -: 2]   = s_r.wgm[1:0];
            end
            OFS_CTRL_B: begin
               s_nxt.rdData[CB_WGM_HI]       = s_r.wgm[WGM_HI_BIT];
               s_nxt.rdData[CB_CS_MSB -: 3]  = s_r.clkSel;
            end
            OFS_COUNT: s_nxt.rdData = s_r.count;
            OFS_CMP_A: s_nxt.rdData = s_r.bufA;
            OFS_CMP_B: s_nxt.rdData = s_r.bufB;
            OFS_FLAGS: begin
               s_nxt.rdData[FL_OVF]   = s_r.ovf;
               s_nxt.rdData[FL_CMP_A] = s_r.flagA;
               s_nxt.rdData[FL_CMP_B] = s_r.flagB;
            end
            default: s_nxt.rdData = '0;
         endcase
      end

      // Pin override depends on the action field only.
      s_nxt.pinA  = (s_nxt.actA != ACT_NONE) ? s_nxt.ocA
                                             : portOutA;
      s_nxt.pinB  = (s_nxt.actB != ACT_NONE) ? s_nxt.ocB
                                             : portOutB;
      s_nxt.oeA_n = ~pinDirectionBitA;
      s_nxt.oeB_n = ~pinDirectionBitB;
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         s_r <= TCW_STATE_RESET;
      else
         s_r <= s_nxt;
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign regRdData      = s_r.rdData;
   assign pinOutA        = s_r.pinA;
   assign pinOutB        = s_r.pinB;
   assign pinOeA_n       = s_r.oeA_n;
   assign pinOeB_n       = s_r.oeB_n;
   assign compareOutputA = s_r.ocA;
   assign compareOutputB = s_r.ocB;
   assign overflowFlag   = s_r.ovf;
   assign compareFlagA   = s_r.flagA;
   assign compareFlagB   = s_r.flagB;

endmodule // tcw_waveform_gen

// *** tb/tcw_checker.sv ***
`timescale 1ns/1ps
module tcw_checker (
   input wire logic                       clk,
   input wire logic                       reset_n,
   input wire logic [tcw_pkg::ADDR_W-1:0] regAddr,
   input wire logic [tcw_pkg::DATA_W-1:0] regWrData,
   input wire logic                       regWrite,
   input wire logic                       regRead,
   input wire logic [tcw_pkg::DATA_W-1:0] regRdData,
   input wire logic                       portOutA,
   input wire logic                       pinDirectionBitA,
   input wire logic                       pinDirectionBitB,
   input wire logic                       pinOutA,
   input wire logic                       pinOeA_n,
   input wire logic                       pinOeB_n,
   input wire logic                       compareOutputA,
   input wire logic                       compareOutputB,
   input wire logic                       overflowFlag,
   input wire logic                       compareFlagA,
   input wire logic                       compareFlagB
);
   import tcw_pkg::*;
   // ------------------------------------------------------------------
   // Shadow of the action fields, rebuilt from bus writes
   // ------------------------------------------------------------------
   logic [1:0] actA_r;
   logic [1:0] actB_r;
   logic       flagWr;
   assign flagWr = regWrite && (regAddr == OFS_FLAGS);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         actA_r <= ACT_NONE;
         actB_r <= ACT_NONE;
      end else if (regWrite && (regAddr == OFS_CTRL_A)) begin
         actA_r <= regWrData[CA_ACT_A_MSB -: 2];
         actB_r <= regWrData[CA_ACT_B_MSB -: 2];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   property p_oeA; 1'b1 |=> (pinOeA_n != $past(pinDirectionBitA)); endproperty
   a_oeA: assert property (p_oeA) else $error("pin A enable wrong");
   property p_oeB; 1'b1 |=> (pinOeB_n != $past(pinDirectionBitB)); endproperty
   a_oeB: assert property (p_oeB) else $error("pin B enable wrong");
   property p_srcA;
      (actA_r == ACT_NONE && !regWrite) |=> (pinOutA == $past(portOutA));
   endproperty
   a_srcA: assert property (p_srcA) else $error("port lost");
   property p_holdA;
      (actA_r == ACT_NONE && !regWrite) |=> $stable(compareOutputA);
   endproperty
   a_holdA: assert property (p_holdA) else $error("latch A moved");
   property p_holdB;
      (actB_r == ACT_NONE && !regWrite) |=> $stable(compareOutputB);
   endproperty
   a_holdB: assert property (p_holdB) else $error("latch B moved");
   property p_ovf;
      (overflowFlag && !(flagWr && regWrData[FL_OVF])) |=> overflowFlag;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag lost");
   property p_fA;
      (compareFlagA && !(flagWr && regWrData[FL_CMP_A])) |=> compareFlagA;
   endproperty
   a_fA: assert property (p_fA) else $error("flag A lost");
   property p_fB;
      (compareFlagB && !(flagWr && regWrData[FL_CMP_B])) |=> compareFlagB;
   endproperty
   a_fB: assert property (p_fB) else $error("flag B lost");
   property p_rdIdle; !regRead |=> (regRdData == 8'h00); endproperty
   a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
endmodule // tcw_checker

bind tcw_waveform_gen tcw_checker u_tcw_checker (.clk(clk), .reset_n(reset_n),
   .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
   .regRead(regRead), .regRdData(regRdData), .portOutA(portOutA),
   .pinDirectionBitA(pinDirectionBitA), .pinDirectionBitB(pinDirectionBitB),
   .pinOutA(pinOutA), .pinOeA_n(pinOeA_n), .pinOeB_n(pinOeB_n),
   .compareOutputA(compareOutputA), .compareOutputB(compareOutputB),
   .overflowFlag(overflowFlag), .compareFlagA(compareFlagA),
   .compareFlagB(compareFlagB));

// *** tb/tcw_port_model.sv ***
`timescale 1ns/1ps
module tcw_port_model (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic dirSetA,
   input  wire logic outSetA,
   input  wire logic pinOutA,
   input  wire logic pinOutB,
   input  wire logic pinOeA_n,
   input  wire logic pinOeB_n,
   output      logic portOutA,
   output      logic portOutB,
   output      logic pinDirectionBitA,
   output      logic pinDirectionBitB,
   output      logic padA,
   output      logic padB
);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         portOutA         <= 1'b0;
         portOutB         <= 1'b0;
         pinDirectionBitA <= 1'b0;
         pinDirectionBitB <= 1'b0;
      end else begin
         portOutA         <= outSetA;
         portOutB         <= !outSetA;
         pinDirectionBitA <= dirSetA;
      end
   end
   // Pads have pull-ups, so a released pin reads high, not its last level.
   assign padA = pinOeA_n ? 1'b1 : pinOutA;
   assign padB = pinOeB_n ? 1'b1 : pinOutB;
endmodule // tcw_port_model

// *** tb/tcw_waveform_gen_bench.sv ***
`timescale 1ns/1ps
module tcw_waveform_gen_bench;
   import tcw_pkg::*;
   logic clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWrData = 8'h00, regRdData;
   logic dirSetA = 1'b0, outSetA = 1'b0, portOutA, portOutB, padA, padB;
   logic pinDirectionBitA, pinDirectionBitB, pinOutA, pinOutB;
   logic pinOeA_n, pinOeB_n, compareOutputA, compareOutputB;
   logic overflowFlag, compareFlagA, compareFlagB;
   int failures = 0, samples_checked = 0;
   always #20 clk = !clk;
   tcw_waveform_gen u_tcw_waveform_gen (.clk(clk), .reset_n(reset_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
      .regRead(regRead), .regRdData(regRdData), .portOutA(portOutA),
      .portOutB(portOutB), .pinDirectionBitA(pinDirectionBitA),
      .pinDirectionBitB(pinDirectionBitB), .pinOutA(pinOutA),
      .pinOutB(pinOutB), .pinOeA_n(pinOeA_n), .pinOeB_n(pinOeB_n),
      .compareOutputA(compareOutputA), .compareOutputB(compareOutputB),
      .overflowFlag(overflowFlag), .compareFlagA(compareFlagA),
      .compareFlagB(compareFlagB));
   tcw_port_model u_tcw_port_model (.clk(clk), .reset_n(reset_n),
      .dirSetA(dirSetA), .outSetA(outSetA), .pinOutA(pinOutA),
      .pinOutB(pinOutB), .pinOeA_n(pinOeA_n), .pinOeB_n(pinOeB_n),
      .portOutA(portOutA), .portOutB(portOutB), .padA(padA), .padB(padB),
      .pinDirectionBitA(pinDirectionBitA),
      .pinDirectionBitB(pinDirectionBitB));
   // ------------------------------------------------------------------
   // Bus and compare tasks
   // ------------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk(regRdData, e);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Counts edges until latch A shows v; a hang ends the run.
   task automatic waitA(input logic v, output int n);
      n = 0;
      while (compareOutputA !== v) begin
         if (n > 1000) begin
            failures++;
            $display("[ERR] %0t latch A wait timed out", $time);
            stop_test();
         end
         tick(1);
         n++;
      end
   endtask
   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      int n;
      int m;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      #1 chk({7'h00, pinOeA_n}, 8'h01);
      for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
      chk({7'h00, compareOutputA}, 8'h00);
      wr(3'h6, 8'hFF);
      rd(3'h6, 8'h00);
      wr(OFS_COUNT, 8'hFE);
      wr(OFS_CTRL_B, {5'h00, CS_DIV1});
      tick(1);
      chk({7'h00, overflowFlag}, 8'h00);
      tick(1);
      chk({7'h00, overflowFlag}, 8'h01);
      rd(OFS_COUNT, 8'h01);
      wr(OFS_CTRL_B, 8'h00);
      wr(OFS_FLAGS, 8'h07);
      rd(OFS_FLAGS, 8'h00);
      // Clear-on-match with toggle, period of three ticks.
      wr(OFS_CTRL_A, 8'h42);
      wr(OFS_CMP_A, 8'h02);
      wr(OFS_COUNT, 8'h00);
      dirSetA <= 1'b1;
      wr(OFS_CTRL_B, {5'h00, CS_DIV1});
      tick(2);
      chk({7'h00, compareFlagA}, 8'h00);
      tick(1);
      chk({7'h00, compareFlagA}, 8'h01);
      chk({7'h00, compareOutputA}, 8'h01);
      tick(3);
      chk({7'h00, compareOutputA}, 8'h00);
      wr(OFS_CTRL_B, 8'h00);
      wr(OFS_FLAGS, 8'h07);
      tick(2);
      chk({7'h00, padA}, 8'h00);
      chk({7'h00, padB}, 8'h01);
      wr(OFS_CTRL_B, 8'h80);
      #1 chk({7'h00, compareOutputA}, 8'h01);
      chk({7'h00, compareFlagA}, 8'h00);
      // Fast PWM to 0xFF, clear on match and set at bottom. The latch is
      // forced low first so that entering the mode has to raise it.
      wr(OFS_CTRL_A, 8'h80);
      wr(OFS_CTRL_B, 8'h80);
      #1 chk({7'h00, compareOutputA}, 8'h00);
      wr(OFS_CMP_A, 8'h10);
      wr(OFS_COUNT, 8'h00);
      wr(OFS_FLAGS, 8'h07);
      wr(OFS_CTRL_A, 8'h83);
      tick(2);
      chk({7'h00, compareOutputA}, 8'h01);
      wr(OFS_CTRL_B, {5'h00, CS_DIV1});
      waitA(1'b0, n);
      chk(8'(n), 8'h11);
      wr(OFS_CMP_A, 8'h40);
      #1 chk({7'h00, overflowFlag}, 8'h00);
      waitA(1'b1, n);
      chk(8'(n), 8'hED);
      chk({7'h00, overflowFlag}, 8'h01);
      waitA(1'b0, n);
      chk(8'(n), 8'h41);
      wr(OFS_CMP_A, 8'hFF);
      waitA(1'b1, n);
      m = 0;
      repeat (300) begin
         tick(1);
         m += int'(compareOutputA !== 1'b1);
      end
      chk(8'(m), 8'h00);
      // Clear-on-match with a count write on the compare value: the
      // blocked match is missed and the counter runs round through MAX.
      wr(OFS_CTRL_B, 8'h00);
      wr(OFS_CTRL_A, 8'h42);
      wr(OFS_CMP_A, 8'h05);
      wr(OFS_FLAGS, 8'h07);
      wr(OFS_COUNT, 8'h05);
      wr(OFS_CTRL_B, {5'h00, CS_DIV1});
      tick(2);
      chk({7'h00, compareFlagA}, 8'h00);
      tick(248);
      chk({7'h00, overflowFlag}, 8'h00);
      tick(1);
      chk({7'h00, overflowFlag}, 8'h01);
      chk({7'h00, compareFlagA}, 8'h00);
      tick(6);
      chk({7'h00, compareFlagA}, 8'h01);
      // A reserved mode select counts straight past compare A.
      wr(OFS_CTRL_B, 8'h00);
      wr(OFS_CTRL_A, 8'h01);
      wr(OFS_CMP_A, 8'h02);
      wr(OFS_COUNT, 8'h00);
      wr(OFS_CTRL_B, {5'h00, CS_DIV1});
      tick(4);
      rd(OFS_COUNT, 8'h05);
      // Fast PWM to MAX with compare at bottom: one high tick a period.
      wr(OFS_CTRL_B, 8'h00);
      wr(OFS_CMP_A, 8'h00);
      wr(OFS_COUNT, 8'hFF);
      wr(OFS_CTRL_A, 8'h83);
      wr(OFS_CTRL_B, {5'h00, CS_DIV1});
      tick(1);
      m = 0;
      repeat (256) begin
         tick(1);
         m += int'(compareOutputA === 1'b1);
      end
      chk(8'(m), 8'h01);
      // Top at compare A with the high mode bit: A toggles every match.
      wr(OFS_CTRL_A, 8'h43);
      wr(OFS_CTRL_B, 8'h09);
      tick(260);
      m = 0;
      repeat (8) begin
         tick(1);
         m += int'(compareOutputA === 1'b1);
      end
      chk(8'(m), 8'h04);
      stop_test();
   end
endmodule // tcw_waveform_gen_bench
